// File: design/abx_alu.sv
// Purpose: add with carry, and, bit clear and the resulting flags
// Assumes: operands stable during the process quarter
// Notes:   flags come out for every op; the caller masks them
`timescale 1ns/1ps
`default_nettype none
`include "abx_cfg.svh"
module abx_alu (
	abx_alu_if.calc bus
);
	logic [4:0] low_sum;
	logic [8:0] full_sum;

	always_comb begin
		low_sum  = {1'b0, bus.work[3:0]} + {1'b0, bus.fval[3:0]} + {4'h0, bus.carry_in};
		full_sum = {1'b0, bus.work} + {1'b0, bus.fval} + {8'h00, bus.carry_in};
		bus.result = bus.fval;
		bus.flags  = 5'h00;
		unique case (bus.op)
			abx_pkg::op_addc: begin
				bus.result = full_sum[7:0];
				bus.flags[`ABX_ST_C]  = full_sum[8];
				bus.flags[`ABX_ST_DC] = low_sum[4];
				bus.flags[`ABX_ST_OV] = (bus.work[7] == bus.fval[7]) && (full_sum[7] != bus.work[7]);
			end
			abx_pkg::op_andl, abx_pkg::op_andf: begin
				bus.result = bus.work & bus.fval;
			end
			abx_pkg::op_bclr: begin
				bus.result = bus.fval & ~(8'h01 << bus.bit_sel);
			end
			abx_pkg::op_none, abx_pkg::op_branch: begin
				bus.result = bus.fval;
			end
		endcase
		bus.flags[`ABX_ST_N] = bus.result[7];
		bus.flags[`ABX_ST_Z] = (bus.result == 8'h00);
	end
endmodule
`default_nettype wire

// File: design/abx_alu_if.sv
// Purpose: operands and results between decoder and arithmetic unit
// Assumes: one clock domain, purely combinational traffic
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface abx_alu_if;
	abx_pkg::abx_op_type op;
	logic [7:0]          work;
	logic [7:0]          fval;
	logic                carry_in;
	logic [2:0]          bit_sel;
	logic [7:0]          result;
	logic [4:0]          flags;

	modport calc (input op, input work, input fval, input carry_in, input bit_sel, output result, output flags);
	modport user (output op, output work, output fval, output carry_in, output bit_sel, input result, input flags);
endinterface
`default_nettype wire

// File: design/abx_cfg.svh
// Purpose: constants of the add, and and branch execution block
// Assumes: included by its bare name
// Notes:   offsets, field positions, opcodes and reset values
`ifndef ABX_CFG_SVH
`define ABX_CFG_SVH

// ----------------------------------------------------------------
// register offsets on the software port
// ----------------------------------------------------------------
`define ABX_REG_WORK   4'h0
`define ABX_REG_STATUS 4'h1
`define ABX_REG_BANK   4'h2
`define ABX_REG_PC     4'h3
`define ABX_REG_CTRL   4'h4

// ----------------------------------------------------------------
// status and control bit positions
// ----------------------------------------------------------------
`define ABX_ST_C   0
`define ABX_ST_DC  1
`define ABX_ST_Z   2
`define ABX_ST_OV  3
`define ABX_ST_N   4
`define ABX_CTL_RUN 0
`define ABX_CTL_EXT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ABX_RST_WORK   8'h00
`define ABX_RST_STATUS 5'h00
`define ABX_RST_BANK   4'h0
`define ABX_RST_PC     14'h0000
`define ABX_RST_RUN    1'b1
`define ABX_RST_EXT    1'b0

// ----------------------------------------------------------------
// opcodes and addressing
// ----------------------------------------------------------------
`define ABX_OPC_ADDC   6'h08
`define ABX_OPC_ANDL   8'h0B
`define ABX_OPC_ANDF   6'h05
`define ABX_OPC_BCLR   4'h9
`define ABX_OPC_BRPFX  4'hE
`define ABX_BR_C       4'h2
`define ABX_BR_NC      4'h3
`define ABX_BR_N       4'h6
`define ABX_BR_NN      4'h7
`define ABX_BR_NOV     4'h5
`define ABX_BR_NZ      4'h1
`define ABX_NOP        16'h0000
`define ABX_IDX_LIMIT  8'h5F
`define ABX_ACC_LOW    4'h0
`define ABX_ACC_HIGH   4'hF
`define ABX_PC_STEP    14'h0002

`endif

// File: design/abx_core.sv
// Purpose: decode and execute of add with carry, and, bit clear and branches
// Assumes: memory and program fetch on the same clock; read data one cycle after strobe
// Notes:   one instruction cycle is four clocks, quarters one to four
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "abx_cfg.svh"
module abx_core (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [15:0] reg_rdata_o,
	input  wire logic [15:0] instr_i,
	output logic      [13:0] pc_o,
	output logic             fetch_o,
	output logic             nop_cycle_o,
	input  wire logic [11:0] index_base_i,
	output logic      [11:0] mem_addr_o,
	output logic             mem_rd_o,
	input  wire logic [7:0]  mem_rdata_i,
	output logic             mem_wr_o,
	output logic      [7:0]  mem_wdata_o
);

	// ----------------------------------------------------------------
	// state and decode helpers
	// ----------------------------------------------------------------
	abx_pkg::abx_state_type cur;
	abx_pkg::abx_state_type next_state;
	abx_pkg::abx_op_type    cur_op;
	logic                   cur_taken;
	logic                   file_op;
	logic                   to_file;
	logic [13:0]            br_offset;

	abx_alu_if alu_bus ();

	abx_alu abx_alu_inst (
		.bus (alu_bus)
	);

	function automatic abx_pkg::abx_op_type decode_op(input logic [15:0] ins);
		abx_pkg::abx_op_type op;
		op = abx_pkg::op_none;
		if (ins[15:10] == `ABX_OPC_ADDC) begin
			op = abx_pkg::op_addc;
		end else if (ins[15:8] == `ABX_OPC_ANDL) begin
			op = abx_pkg::op_andl;
		end else if (ins[15:10] == `ABX_OPC_ANDF) begin
			op = abx_pkg::op_andf;
		end else if (ins[15:12] == `ABX_OPC_BCLR) begin
			op = abx_pkg::op_bclr;
		end else if (ins[15:12] == `ABX_OPC_BRPFX && (ins[11:8] == `ABX_BR_C || ins[11:8] == `ABX_BR_NC
				|| ins[11:8] == `ABX_BR_N || ins[11:8] == `ABX_BR_NN
				|| ins[11:8] == `ABX_BR_NOV || ins[11:8] == `ABX_BR_NZ)) begin
			op = abx_pkg::op_branch;
		end
		return op;
	endfunction

	function automatic logic branch_true(input logic [3:0] code, input logic [4:0] st);
		logic hit;
		hit = 1'b0;
		unique case (code)
			`ABX_BR_C:   hit = st[`ABX_ST_C];
			`ABX_BR_NC:  hit = !st[`ABX_ST_C];
			`ABX_BR_N:   hit = st[`ABX_ST_N];
			`ABX_BR_NN:  hit = !st[`ABX_ST_N];
			`ABX_BR_NOV: hit = !st[`ABX_ST_OV];
			`ABX_BR_NZ:  hit = !st[`ABX_ST_Z];
			default:     hit = 1'b0;
		endcase
		return hit;
	endfunction

	// access bank splits at 60h; the part below 60h turns indexed when extension is on
	function automatic logic [11:0] form_addr(input logic [15:0] ins, input logic [3:0] bank,
			input logic ext, input logic [11:0] base);
		logic [11:0] a;
		a = {bank, ins[7:0]};
		if (!ins[8]) begin
			if (ext && ins[7:0] <= `ABX_IDX_LIMIT) begin
				a = base + {4'h0, ins[7:0]};
			end else if (ins[7:0] <= `ABX_IDX_LIMIT) begin
				a = {`ABX_ACC_LOW, ins[7:0]};
			end else begin
				a = {`ABX_ACC_HIGH, ins[7:0]};
			end
		end
		return a;
	endfunction

	assign cur_op    = decode_op(cur.instr);
	assign cur_taken = (cur_op == abx_pkg::op_branch) && branch_true(cur.instr[11:8], cur.status);
	assign file_op   = (cur_op == abx_pkg::op_addc) || (cur_op == abx_pkg::op_andf) || (cur_op == abx_pkg::op_bclr);
	assign to_file   = (cur_op == abx_pkg::op_bclr) || (file_op && cur.instr[9]);
	assign br_offset = {{5{cur.instr[7]}}, cur.instr[7:0], 1'b0};

	// ----------------------------------------------------------------
	// arithmetic unit hookup
	// ----------------------------------------------------------------
	assign alu_bus.op       = cur_op;
	assign alu_bus.work     = cur.work;
	assign alu_bus.fval     = (cur_op == abx_pkg::op_andl) ? cur.instr[7:0] : mem_rdata_i;
	assign alu_bus.carry_in = cur.status[`ABX_ST_C];
	assign alu_bus.bit_sel  = cur.instr[11:9];

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata_o = cur.rdata;
	assign pc_o        = cur.pc;
	assign fetch_o     = cur.run && (cur.quarter == abx_pkg::q_one);
	assign nop_cycle_o = cur.skip;
	assign mem_addr_o  = cur.addr;
	assign mem_rd_o    = cur.run && (cur.quarter == abx_pkg::q_two) && file_op;
	assign mem_wr_o    = cur.run && (cur.quarter == abx_pkg::q_four) && to_file;
	assign mem_wdata_o = cur.result;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = cur;
		next_state.rdata = 16'h0000;
		if (cur.run) begin
			unique case (cur.quarter)
				abx_pkg::q_one: begin
					next_state.quarter = abx_pkg::q_two;
					// a flushed slot decodes as a no-operation
					next_state.instr = cur.skip ? `ABX_NOP : instr_i;
					next_state.skip  = 1'b0;
					// flushed slot holds the counter so the branch target is fetched next
					next_state.pc    = cur.skip ? cur.pc : cur.pc + `ABX_PC_STEP;
					next_state.addr  = form_addr(instr_i, cur.bank, cur.ext_en, index_base_i);
				end
				abx_pkg::q_two: begin
					next_state.quarter = abx_pkg::q_three;
				end
				abx_pkg::q_three: begin
					next_state.quarter = abx_pkg::q_four;
					next_state.result  = alu_bus.result;
					next_state.flags   = alu_bus.flags;
				end
				abx_pkg::q_four: begin
					next_state.quarter = abx_pkg::q_one;
					if (cur_op == abx_pkg::op_andl || ((cur_op == abx_pkg::op_addc
							|| cur_op == abx_pkg::op_andf) && !cur.instr[9])) begin
						next_state.work = cur.result;
					end
					if (cur_op == abx_pkg::op_addc) begin
						next_state.status = cur.flags;
					end
					if (cur_op == abx_pkg::op_andl || cur_op == abx_pkg::op_andf) begin
						next_state.status[`ABX_ST_N] = cur.flags[`ABX_ST_N];
						next_state.status[`ABX_ST_Z] = cur.flags[`ABX_ST_Z];
					end
					if (cur_taken) begin
						next_state.pc   = cur.pc + br_offset;
						next_state.skip = 1'b1;
					end
				end
			endcase
		end
		// software access goes last so a write in the same cycle wins
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`ABX_REG_WORK:   next_state.work   = reg_wdata_i[7:0];
				`ABX_REG_STATUS: next_state.status = reg_wdata_i[4:0];
				`ABX_REG_BANK:   next_state.bank   = reg_wdata_i[3:0];
				`ABX_REG_PC:     next_state.pc     = {reg_wdata_i[13:1], 1'b0};
				`ABX_REG_CTRL: begin
					next_state.run    = reg_wdata_i[`ABX_CTL_RUN];
					next_state.ext_en = reg_wdata_i[`ABX_CTL_EXT];
				end
				default: begin
				end
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`ABX_REG_WORK:   next_state.rdata = {8'h00, cur.work};
				`ABX_REG_STATUS: next_state.rdata = {11'h000, cur.status};
				`ABX_REG_BANK:   next_state.rdata = {12'h000, cur.bank};
				`ABX_REG_PC:     next_state.rdata = {2'h0, cur.pc};
				`ABX_REG_CTRL:   next_state.rdata = {13'h0000, cur.skip, cur.ext_en, cur.run};
				default:         next_state.rdata = 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cur.quarter <= abx_pkg::q_one;
			cur.instr   <= `ABX_NOP;
			cur.addr    <= 12'h000;
			cur.result  <= 8'h00;
			cur.flags   <= 5'h00;
			cur.work    <= `ABX_RST_WORK;
			cur.status  <= `ABX_RST_STATUS;
			cur.bank    <= `ABX_RST_BANK;
			cur.pc      <= `ABX_RST_PC;
			cur.run     <= `ABX_RST_RUN;
			cur.ext_en  <= `ABX_RST_EXT;
			cur.skip    <= 1'b0;
			cur.rdata   <= 16'h0000;
		end else begin
			cur <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	add_carry_sum_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_three && cur_op == abx_pkg::op_addc && !reg_wr_i
		|=> cur.result == 8'($past(cur.work) + $past(mem_rdata_i) + {7'h00, $past(cur.status[`ABX_ST_C])}))
		else $error("add with carry result wrong");

	add_flags_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && cur_op == abx_pkg::op_addc && !reg_wr_i
		|=> cur.status == $past(cur.flags) && cur.status[`ABX_ST_Z] == ($past(cur.result) == 8'h00))
		else $error("add flags not taken");

	dest_work_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && file_op && cur_op != abx_pkg::op_bclr && !reg_wr_i
		|-> mem_wr_o == cur.instr[9] and (cur.instr[9] or ##1 cur.work == $past(cur.result)))
		else $error("destination select wrong");

	bank_addr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.quarter == abx_pkg::q_two && $past(cur.run) && cur.instr[8] && !cur.skip
		|-> mem_addr_o == {$past(cur.bank), cur.instr[7:0]})
		else $error("banked address wrong");

	indexed_addr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.quarter == abx_pkg::q_two && $past(cur.run) && !cur.instr[8] && $past(cur.ext_en) && !$past(cur.skip)
		&& cur.instr[7:0] <= `ABX_IDX_LIMIT
		|-> mem_addr_o == $past(index_base_i) + {4'h0, cur.instr[7:0]})
		else $error("indexed address wrong");

	and_flags_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && !reg_wr_i
		&& (cur_op == abx_pkg::op_andl || cur_op == abx_pkg::op_andf)
		|=> cur.status[`ABX_ST_C] == $past(cur.status[`ABX_ST_C]) && cur.status[`ABX_ST_OV] == $past(cur.status[`ABX_ST_OV])
		&& cur.status[`ABX_ST_DC] == $past(cur.status[`ABX_ST_DC]))
		else $error("and altered other flags");

	branch_target_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && cur_taken && !reg_wr_i
		|=> cur.pc == $past(cur.pc) + $past(br_offset) && cur.skip)
		else $error("branch target wrong");

	branch_cycles_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && cur_op == abx_pkg::op_branch && !cur_taken && !reg_wr_i
		|=> !cur.skip && cur.pc == $past(cur.pc))
		else $error("untaken branch cost a cycle");

	flush_slot_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.skip && cur.quarter == abx_pkg::q_one && !reg_wr_i
		|=> cur.instr == `ABX_NOP && !mem_rd_o ##2 !mem_wr_o)
		else $error("second cycle not a no-operation");

	bit_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && cur_op == abx_pkg::op_bclr && !reg_wr_i
		|-> mem_wr_o && !mem_wdata_o[cur.instr[11:9]] ##1 cur.status == $past(cur.status))
		else $error("bit clear wrong");

	flush_pc_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.skip && cur.quarter == abx_pkg::q_one && !reg_wr_i
		|=> cur.pc == $past(cur.pc))
		else $error("flushed slot moved the counter");

	access_bank_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.quarter == abx_pkg::q_two && $past(cur.run) && !$past(cur.skip) && !cur.instr[8]
		&& !($past(cur.ext_en) && cur.instr[7:0] <= `ABX_IDX_LIMIT)
		|-> mem_addr_o == {(cur.instr[7:0] <= `ABX_IDX_LIMIT) ? `ABX_ACC_LOW : `ABX_ACC_HIGH, cur.instr[7:0]})
		else $error("access bank address wrong");

	and_literal_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_three && cur_op == abx_pkg::op_andl
		|=> cur.result == ($past(cur.work) & $past(cur.instr[7:0])))
		else $error("and literal result wrong");

	and_file_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_three && cur_op == abx_pkg::op_andf
		|=> cur.result == ($past(cur.work) & $past(mem_rdata_i)))
		else $error("and file result wrong");

	// ----------------------------------------------------------------
	// branch decisions, judged by the flush that follows
	// ----------------------------------------------------------------
	branch_carry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && cur.instr[15:8] == {`ABX_OPC_BRPFX, `ABX_BR_C}
		|=> cur.skip == $past(cur.status[`ABX_ST_C]))
		else $error("carry branch decision wrong");

	branch_no_carry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && cur.instr[15:8] == {`ABX_OPC_BRPFX, `ABX_BR_NC}
		|=> cur.skip == !$past(cur.status[`ABX_ST_C]))
		else $error("no carry branch decision wrong");

	branch_neg_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && cur.instr[15:8] == {`ABX_OPC_BRPFX, `ABX_BR_N}
		|=> cur.skip == $past(cur.status[`ABX_ST_N]))
		else $error("negative branch decision wrong");

	branch_not_neg_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && cur.instr[15:8] == {`ABX_OPC_BRPFX, `ABX_BR_NN}
		|=> cur.skip == !$past(cur.status[`ABX_ST_N]))
		else $error("not negative branch decision wrong");

	branch_no_ovf_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && cur.instr[15:8] == {`ABX_OPC_BRPFX, `ABX_BR_NOV}
		|=> cur.skip == !$past(cur.status[`ABX_ST_OV]))
		else $error("no overflow branch decision wrong");

	branch_not_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cur.run && cur.quarter == abx_pkg::q_four && cur.instr[15:8] == {`ABX_OPC_BRPFX, `ABX_BR_NZ}
		|=> cur.skip == !$past(cur.status[`ABX_ST_Z]))
		else $error("not zero branch decision wrong");

endmodule
`default_nettype wire

// File: design/abx_pkg.sv
// Purpose: shared types of the execution block
// Assumes: nothing
// Notes:   constants live in abx_cfg.svh
`default_nettype none
package abx_pkg;

	typedef enum logic [1:0] {q_one, q_two, q_three, q_four} abx_quarter_type;

	typedef enum logic [2:0] {op_none, op_addc, op_andl, op_andf, op_bclr, op_branch} abx_op_type;

	typedef struct packed {
		abx_quarter_type quarter;
		logic [15:0]     instr;
		logic [11:0]     addr;
		logic [7:0]      result;
		logic [4:0]      flags;
		logic [7:0]      work;
		logic [4:0]      status;
		logic [3:0]      bank;
		logic [13:0]     pc;
		logic            run;
		logic            ext_en;
		logic            skip;
		logic [15:0]     rdata;
	} abx_state_type;

endpackage
`default_nettype wire

// File: testbench/add_and_branch_instruction_exec_bench.sv
// Purpose: self-checking bench of the add, and, bit clear and branch execution core
// Assumes: bench plays program and data memory; memory data held for the whole instruction
// Notes:   instruction word returns to no-operation right after its fetch edge
`timescale 1ns/1ps
`default_nettype none
`include "abx_cfg.svh"
module add_and_branch_instruction_exec_bench;
	logic        clk;
	logic        rst_n;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [15:0] instr;
	logic [13:0] pc;
	logic        fetch;
	logic        nop_cycle;
	logic [11:0] index_base;
	logic [11:0] mem_addr;
	logic        mem_rd;
	logic [7:0]  mem_rdata;
	logic        mem_wr;
	logic [7:0]  mem_wdata;
	int          errors;
	int          n_tests;
	logic        s_rd;
	logic        s_wr;
	logic        s_nop4;
	logic [11:0] s_addr;
	logic [7:0]  s_wdata;
	logic [13:0] s_pc0;
	logic [13:0] s_pc4;
	logic [15:0] rv;

	abx_core abx_core_inst (
		.core_clk_i   (clk),
		.rst_n_i      (rst_n),
		.reg_addr_i   (reg_addr),
		.reg_wdata_i  (reg_wdata),
		.reg_wr_i     (reg_wr),
		.reg_rd_i     (reg_rd),
		.reg_rdata_o  (reg_rdata),
		.instr_i      (instr),
		.pc_o         (pc),
		.fetch_o      (fetch),
		.nop_cycle_o  (nop_cycle),
		.index_base_i (index_base),
		.mem_addr_o   (mem_addr),
		.mem_rd_o     (mem_rd),
		.mem_rdata_i  (mem_rdata),
		.mem_wr_o     (mem_wr),
		.mem_wdata_o  (mem_wdata)
	);

	// ----------------------------------------------------------------
	// clock and shared tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// one instruction; observes quarters two and four and the next quarter one
	task automatic run_op(input logic [15:0] ins, input logic [7:0] b);
		int k;
		instr     <= ins;
		mem_rdata <= b;
		// settle first: right after a write edge fetch still shows the old quarter
		@(negedge clk);
		for (k = 0; k < 12 && fetch !== 1'b1; k++) begin
			@(negedge clk);
		end
		if (fetch !== 1'b1) begin
			errors++;
		end
		s_pc0 = pc;
		@(posedge clk);
		instr <= `ABX_NOP;
		@(negedge clk);
		s_rd   = mem_rd;
		s_addr = mem_addr;
		repeat (2) @(negedge clk);
		s_wr    = mem_wr;
		s_wdata = mem_wdata;
		@(negedge clk);
		s_pc4  = pc;
		s_nop4 = nop_cycle;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		reg_read(`ABX_REG_WORK, rv);   check(rv, 16'h0000);
		reg_read(`ABX_REG_STATUS, rv); check(rv, 16'h0000);
		reg_read(`ABX_REG_BANK, rv);   check(rv, 16'h0000);
		reg_read(`ABX_REG_CTRL, rv);   check(rv, 16'h0001);
		reg_read(4'h7, rv);            check(rv, 16'h0000);
	endtask

	task automatic t_addc;
		reg_write(`ABX_REG_WORK, 16'h0002);
		reg_write(`ABX_REG_STATUS, 16'h0001);
		reg_write(`ABX_REG_BANK, 16'h0003);
		run_op(16'h234D, 8'h4D);
		check({4'h0, s_addr}, 16'h034D);
		check({15'h0, s_rd}, 16'h0001);
		check({15'h0, s_wr}, 16'h0001);
		check({8'h00, s_wdata}, 16'h0050);
		reg_read(`ABX_REG_STATUS, rv); check(rv, 16'h0002);
		reg_read(`ABX_REG_WORK, rv);   check(rv, 16'h0002);
		// carry out, zero and signed overflow all at once
		reg_write(`ABX_REG_WORK, 16'h0080);
		reg_write(`ABX_REG_STATUS, 16'h0000);
		run_op(16'h2080, 8'h80);
		check({4'h0, s_addr}, 16'h0F80);
		check({15'h0, s_wr}, 16'h0000);
		reg_read(`ABX_REG_WORK, rv);   check(rv, 16'h0000);
		reg_read(`ABX_REG_STATUS, rv); check(rv, 16'h000D);
	endtask

	task automatic t_and;
		reg_write(`ABX_REG_WORK, 16'h00A3);
		reg_write(`ABX_REG_STATUS, 16'h000B);
		run_op(16'h0B5F, 8'hFF);
		check({15'h0, s_rd}, 16'h0000);
		reg_read(`ABX_REG_WORK, rv);   check(rv, 16'h0003);
		reg_read(`ABX_REG_STATUS, rv); check(rv, 16'h000B);
		run_op(16'h1620, 8'hC0);
		check({4'h0, s_addr}, 16'h0020);
		check({7'h00, s_wr, s_wdata}, 16'h0100);
		reg_read(`ABX_REG_STATUS, rv); check(rv, 16'h000F);
		// extension on: offset 5Fh is the last indexed one
		reg_write(`ABX_REG_CTRL, 16'h0003);
		index_base <= 12'h100;
		run_op(16'h145F, 8'h81);
		check({4'h0, s_addr}, 16'h015F);
		reg_read(`ABX_REG_WORK, rv);   check(rv, 16'h0001);
		reg_read(`ABX_REG_STATUS, rv); check(rv, 16'h000B);
	endtask

	task automatic t_bclr;
		run_op(16'h9E60, 8'hC7);
		check({4'h0, s_addr}, 16'h0F60);
		check({7'h00, s_wr, s_wdata}, 16'h0147);
		check({15'h0, s_nop4}, 16'h0000);
		reg_read(`ABX_REG_STATUS, rv); check(rv, 16'h000B);
		reg_write(`ABX_REG_CTRL, 16'h0001);
	endtask

	// each code once taken and once not taken
	task automatic t_branch(input logic [3:0] code, input int fb, input logic want, input logic [7:0] n);
		logic [15:0] sv;
		logic [13:0] e;
		int          k;
		for (k = 0; k < 2; k++) begin
			sv     = 16'h0000;
			sv[fb] = (k == 0) ? want : ~want;
			reg_write(`ABX_REG_STATUS, sv);
			run_op({4'hE, code, n}, 8'h00);
			// after the flushed slot the target itself is fetched
			if (k == 1) begin
				check({2'b00, s_pc0}, {2'b00, e});
			end
			e = (k == 0) ? s_pc0 + 14'h0002 + {{5{n[7]}}, n, 1'b0} : s_pc0 + 14'h0002;
			check({2'b00, s_pc4}, {2'b00, e});
			check({15'h0, s_nop4}, {15'h0, k == 0});
			check({15'h0, s_wr}, 16'h0000);
			reg_read(`ABX_REG_STATUS, rv); check(rv, sv);
		end
	endtask

	task automatic t_freeze;
		int k;
		reg_write(`ABX_REG_CTRL, 16'h0000);
		repeat (2) @(negedge clk);
		s_pc0 = pc;
		for (k = 0; k < 8; k++) begin
			@(negedge clk);
			check({15'h0, fetch}, 16'h0000);
		end
		check({2'b00, pc}, {2'b00, s_pc0});
		reg_write(`ABX_REG_CTRL, 16'h0001);
	endtask

	// ----------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ----------------------------------------------------------------
	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		summarize();
	end

	initial begin
		errors     = 0;
		n_tests    = 0;
		rst_n      = 1'b0;
		reg_addr   = 4'h0;
		reg_wdata  = 16'h0000;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		instr      = `ABX_NOP;
		index_base = 12'h000;
		mem_rdata  = 8'h00;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_addc();
		t_and();
		t_bclr();
		t_branch(`ABX_BR_C, `ABX_ST_C, 1'b1, 8'h80);
		t_branch(`ABX_BR_NC, `ABX_ST_C, 1'b0, 8'h7F);
		t_branch(`ABX_BR_N, `ABX_ST_N, 1'b1, 8'h05);
		t_branch(`ABX_BR_NN, `ABX_ST_N, 1'b0, 8'hFE);
		t_branch(`ABX_BR_NOV, `ABX_ST_OV, 1'b0, 8'h80);
		t_branch(`ABX_BR_NZ, `ABX_ST_Z, 1'b0, 8'h7F);
		t_freeze();
		summarize();
	end
endmodule
`default_nettype wire
